// [shared/dtc_map.vh]
// Register map, field positions, reset values and codes of the dual timer block
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// Register indices (printed offsets are not all multiples of four)
`define DTC_IDX_A_CTRL     8'h18
`define DTC_IDX_B_CTRL     8'h19
`define DTC_IDX_A_PERIOD   8'h1a
`define DTC_IDX_A_PULSE    8'h1b
`define DTC_IDX_B_PERIOD   8'h1c
`define DTC_IDX_B_PULSE    8'h1d
`define DTC_IDX_MISC       8'h1e
`define DTC_IDX_STATUS     8'h1f
`define DTC_IDX_MASK       8'h20
`define DTC_IDX_COUNT      8'h21

// Control register fields
`define DTC_FF_BIT         7
`define DTC_CK_HI          6
`define DTC_CK_LO          4
`define DTC_RUN_BIT        3
`define DTC_MODE_HI        2
`define DTC_MODE_LO        0
`define DTC_CTRL_RST       8'h00

// Misc register fields
`define DTC_MISC_TAP_BIT   0
`define DTC_MISC_SLOW_BIT  1
`define DTC_MISC_RST       8'h00

// Mode codes
`define DTC_MODE_PDO       3'h1
`define DTC_MODE_PWM       3'h2
`define DTC_MODE_16        3'h3

// Clock select codes
`define DTC_CK_DIV11       3'h0
`define DTC_CK_DIV7        3'h1
`define DTC_CK_DIV5        3'h2
`define DTC_CK_DIV3        3'h3
`define DTC_CK_FS          3'h4
`define DTC_CK_DIV1        3'h5
`define DTC_CK_FC          3'h6
`define DTC_CK_EXT         3'h7

// Status bits
`define DTC_ST_A_MATCH     0
`define DTC_ST_B_MATCH     1

`endif

// [src/dtc_tick_sel.v]
// Source clock tick selection for one timer channel
`timescale 1ns/1ps
`include "dtc_map.vh"

module dtc_tick_sel
(
    input  wire [2:0]  clk_sel,
    input  wire        tap_sel,
    input  wire        slow_mode,
    input  wire [11:0] fc_div,
    input  wire        fs_tick,
    input  wire        fs8_tick,
    input  wire        ext_tick,
    output reg         tick
);

    // One-cycle tick per selected prescaler tap
    always @*
    begin
        case (clk_sel)
            `DTC_CK_DIV11: tick = (tap_sel | slow_mode) ? fs8_tick : (fc_div[10:0] == 11'h7ff);
            `DTC_CK_DIV7:  tick = fc_div[6:0] == 7'h7f;
            `DTC_CK_DIV5:  tick = fc_div[4:0] == 5'h1f;
            `DTC_CK_DIV3:  tick = fc_div[2:0] == 3'h7;
            `DTC_CK_FS:    tick = fs_tick;
            `DTC_CK_DIV1:  tick = fc_div[0];
            `DTC_CK_FC:    tick = 1'b1;
            `DTC_CK_EXT:   tick = ext_tick;
            default:       tick = 1'b0;
        endcase
    end

endmodule

// [src/dtc_top.v]
// Dual 8-bit timer control block with APB register access
`timescale 1ns/1ps
`include "dtc_map.vh"

module dtc_top
(
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        fs_pulse,
    input  wire        timer_a_pin,
    input  wire        timer_b_pin,
    output wire        timer_a_out,
    output wire        timer_b_out,
    output wire        irq
);

    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    reg  [7:0]  timer_a_control_q;
    reg  [7:0]  timer_b_control_q;
    reg  [7:0]  timer_a_period_q;
    reg  [7:0]  timer_a_pulse_q;
    reg  [7:0]  timer_b_period_q;
    reg  [7:0]  timer_b_pulse_q;
    reg  [7:0]  misc_q;
    reg  [1:0]  status_q;
    reg  [1:0]  mask_q;
    reg  [7:0]  cnt_a_q;
    reg  [7:0]  cnt_b_q;
    reg         ff_a_q;
    reg         ff_b_q;
    reg  [11:0] fc_div_q;
    reg  [2:0]  fs_div_q;
    reg  [2:0]  fs_sync_q;
    reg  [2:0]  pa_sync_q;
    reg  [2:0]  pb_sync_q;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------

    // Byte address is four times the index
    function [7:0] word_idx;
        input [11:0] addr;
        begin
            word_idx = addr[9:2];
        end
    endfunction

    function sel_hit;
        input [7:0] idx;
        input [7:0] want;
        begin
            sel_hit = idx == want;
        end
    endfunction

    wire [7:0] idx      = word_idx(paddr);
    wire       wr_en    = psel & penable & pwrite & pstrb[0] & ~pslverr;
    wire       mapped   = (idx >= `DTC_IDX_A_CTRL) && (idx <= `DTC_IDX_COUNT);

    // Zero wait states; unmapped or misaligned accesses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (~mapped | (paddr[1:0] != 2'h0));

    // ----------------------------------------------------------------
    // Derived controls
    // ----------------------------------------------------------------
    wire [2:0] mode_a   = timer_a_control_q[`DTC_MODE_HI:`DTC_MODE_LO];
    wire [2:0] mode_b   = timer_b_control_q[`DTC_MODE_HI:`DTC_MODE_LO];
    wire       chain    = mode_a == `DTC_MODE_16;
    wire       run_a    = chain ? timer_b_control_q[`DTC_RUN_BIT]
                                : timer_a_control_q[`DTC_RUN_BIT];
    wire       run_b    = timer_b_control_q[`DTC_RUN_BIT];
    wire       init_a   = chain ? timer_b_control_q[`DTC_FF_BIT]
                                : timer_a_control_q[`DTC_FF_BIT];
    wire       init_b   = timer_b_control_q[`DTC_FF_BIT];
    wire       tap_sel  = misc_q[`DTC_MISC_TAP_BIT];
    wire       slow     = misc_q[`DTC_MISC_SLOW_BIT];

    // Pin and low-speed clock rising edges, second synchroniser stage compared against the third
    wire       fs_tick  = fs_sync_q[1] & ~fs_sync_q[2];
    wire       fs8_tick = fs_tick & (fs_div_q == 3'h7);
    wire       pa_tick  = pa_sync_q[1] & ~pa_sync_q[2];
    wire       pb_tick  = pb_sync_q[1] & ~pb_sync_q[2];

    wire       tick_a;
    wire       tick_b;

    // ----------------------------------------------------------------
    // Tick selection per channel
    // ----------------------------------------------------------------
    dtc_tick_sel u_tick_a
    (
        .clk_sel   (timer_a_control_q[`DTC_CK_HI:`DTC_CK_LO]),
        .tap_sel   (tap_sel),
        .slow_mode (slow),
        .fc_div    (fc_div_q),
        .fs_tick   (fs_tick),
        .fs8_tick  (fs8_tick),
        .ext_tick  (pa_tick),
        .tick      (tick_a)
    );

    dtc_tick_sel u_tick_b
    (
        .clk_sel   (timer_b_control_q[`DTC_CK_HI:`DTC_CK_LO]),
        .tap_sel   (tap_sel),
        .slow_mode (slow),
        .fc_div    (fc_div_q),
        .fs_tick   (fs_tick),
        .fs8_tick  (fs8_tick),
        .ext_tick  (pb_tick),
        .tick      (tick_b)
    );

    // ----------------------------------------------------------------
    // Match logic
    // ----------------------------------------------------------------
    // In chained mode timer A is the low byte, B the high byte
    wire        match16  = chain && ({cnt_b_q, cnt_a_q} == {timer_b_period_q, timer_a_period_q});
    wire        match_a  = run_a & tick_a & (chain ? match16 : cnt_a_q == timer_a_period_q);
    wire        match_b  = ~chain & run_b & tick_b & (cnt_b_q == timer_b_period_q);
    wire        pwm_a    = run_a & tick_a & ~chain & (mode_a == `DTC_MODE_PWM)
                           & (cnt_a_q == timer_a_pulse_q);
    wire        pwm_b    = run_b & tick_b & ~chain & (mode_b == `DTC_MODE_PWM)
                           & (cnt_b_q == timer_b_pulse_q);
    wire        pwm16    = run_a & tick_a & chain & (mode_b == `DTC_MODE_PWM)
                           & ({cnt_b_q, cnt_a_q} == {timer_b_pulse_q, timer_a_pulse_q});

    assign timer_a_out = ff_a_q;
    assign timer_b_out = ff_b_q;
    assign irq         = |(status_q & mask_q);

    // ----------------------------------------------------------------
    // Synchronisers and prescalers
    // ----------------------------------------------------------------

    // Two flops before use; third flop only stores the previous level for edges
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            fs_sync_q <= 3'h0;
            pa_sync_q <= 3'h0;
            pb_sync_q <= 3'h0;
            fc_div_q  <= 12'h000;
            fs_div_q  <= 3'h0;
        end
        else if (clk_en)
        begin
            fs_sync_q <= {fs_sync_q[1:0], fs_pulse};
            pa_sync_q <= {pa_sync_q[1:0], timer_a_pin};
            pb_sync_q <= {pb_sync_q[1:0], timer_b_pin};
            fc_div_q  <= fc_div_q + 12'h001;
            if (fs_tick)
                fs_div_q <= fs_div_q + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------

    // Period and pulse writes are not blocked while running; software keeps off
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            timer_a_control_q <= `DTC_CTRL_RST;
            timer_b_control_q <= `DTC_CTRL_RST;
            timer_a_period_q  <= 8'h00;
            timer_a_pulse_q   <= 8'h00;
            timer_b_period_q  <= 8'h00;
            timer_b_pulse_q   <= 8'h00;
            misc_q            <= `DTC_MISC_RST;
            mask_q            <= 2'h0;
        end
        else if (clk_en && wr_en)
        begin
            if (sel_hit(idx, `DTC_IDX_A_CTRL))
                timer_a_control_q <= pwdata[7:0];
            if (sel_hit(idx, `DTC_IDX_B_CTRL))
                timer_b_control_q <= pwdata[7:0];
            if (sel_hit(idx, `DTC_IDX_A_PERIOD))
                timer_a_period_q <= pwdata[7:0];
            if (sel_hit(idx, `DTC_IDX_A_PULSE))
                timer_a_pulse_q <= pwdata[7:0];
            if (sel_hit(idx, `DTC_IDX_B_PERIOD))
                timer_b_period_q <= pwdata[7:0];
            if (sel_hit(idx, `DTC_IDX_B_PULSE))
                timer_b_pulse_q <= pwdata[7:0];
            if (sel_hit(idx, `DTC_IDX_MISC))
                misc_q <= {6'h00, pwdata[1:0]};
            if (sel_hit(idx, `DTC_IDX_MASK))
                mask_q <= pwdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------

    // Write one to clear; a match in the same cycle wins over the clear
    always @(posedge clk_sys)
    begin
        if (sys_rst)
            status_q <= 2'h0;
        else if (clk_en)
        begin
            status_q <= (status_q & ~((wr_en && sel_hit(idx, `DTC_IDX_STATUS))
                                      ? pwdata[1:0] : 2'h0))
                        | {match_b, match_a};
        end
    end

    // ----------------------------------------------------------------
    // Counters and flip-flops
    // ----------------------------------------------------------------

    // Stopped counters sit at zero with the flip-flop at its initial value
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cnt_a_q <= 8'h00;
            cnt_b_q <= 8'h00;
            ff_a_q  <= 1'b0;
            ff_b_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!run_a)
            begin
                cnt_a_q <= 8'h00;
                ff_a_q  <= init_a;
            end
            else if (tick_a)
            begin
                if (match_a)
                begin
                    cnt_a_q <= 8'h00;
                    ff_a_q  <= (chain ? mode_b : mode_a) == `DTC_MODE_PWM
                               ? init_a : ~ff_a_q;
                end
                else
                begin
                    cnt_a_q <= cnt_a_q + 8'h01;
                    if (pwm_a | pwm16)
                        ff_a_q <= ~init_a;
                end
            end

            // Chained: B is the high byte and carries on A wrap
            if (chain)
            begin
                ff_b_q <= ff_a_q;
                if (!run_a || match_a)
                    cnt_b_q <= 8'h00;
                else if (tick_a && cnt_a_q == 8'hff)
                    cnt_b_q <= cnt_b_q + 8'h01;
            end
            else if (!run_b)
            begin
                cnt_b_q <= 8'h00;
                ff_b_q  <= init_b;
            end
            else if (tick_b)
            begin
                if (match_b)
                begin
                    cnt_b_q <= 8'h00;
                    ff_b_q  <= mode_b == `DTC_MODE_PWM ? init_b : ~ff_b_q;
                end
                else
                begin
                    cnt_b_q <= cnt_b_q + 8'h01;
                    if (pwm_b)
                        ff_b_q <= ~init_b;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------

    // Registered so data follows one cycle after setup, valid at access
    always @(posedge clk_sys)
    begin
        if (sys_rst)
            prdata <= 32'h0000_0000;
        else if (clk_en && psel && !penable && !pwrite)
        begin
            case (idx)
                `DTC_IDX_A_CTRL:   prdata <= {24'h000000, timer_a_control_q};
                `DTC_IDX_B_CTRL:   prdata <= {24'h000000, timer_b_control_q};
                `DTC_IDX_A_PERIOD: prdata <= {24'h000000, timer_a_period_q};
                `DTC_IDX_A_PULSE:  prdata <= {24'h000000, timer_a_pulse_q};
                `DTC_IDX_B_PERIOD: prdata <= {24'h000000, timer_b_period_q};
                `DTC_IDX_B_PULSE:  prdata <= {24'h000000, timer_b_pulse_q};
                `DTC_IDX_MISC:     prdata <= {24'h000000, misc_q};
                `DTC_IDX_STATUS:   prdata <= {30'h0, status_q};
                `DTC_IDX_MASK:     prdata <= {30'h0, mask_q};
                `DTC_IDX_COUNT:    prdata <= {14'h0, ff_b_q, ff_a_q, cnt_b_q, cnt_a_q};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// [test/dtc_top_properties.sv]
// Port-level assertions for the dual timer control block
`timescale 1ns/1ps

module dtc_top_properties
(
    input wire        clk_sys,
    input wire        sys_rst,
    input wire        clk_en,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        fs_pulse,
    input wire        timer_a_pin,
    input wire        timer_b_pin,
    input wire        timer_a_out,
    input wire        timer_b_out,
    input wire        irq
);
    reg  [7:0] a_sh_q;
    reg  [7:0] b_sh_q;
    reg  [7:0] m_sh_q;
    wire       wr_go = psel && penable && pwrite && pstrb[0] && clk_en;
    wire       m16   = (a_sh_q[2:0] == 3'h3);
    wire       ok_ix = (paddr[9:2] >= 8'h18) && (paddr[9:2] <= 8'h21) && (paddr[1:0] == 2'b00);

    // Shadows of control and mask, so outputs can be tied to what software wrote
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            a_sh_q <= 8'h00;
            b_sh_q <= 8'h00;
            m_sh_q <= 8'h00;
        end
        else if (wr_go)
        begin
            case (paddr)
                12'h060: a_sh_q <= pwdata[7:0];
                12'h064: b_sh_q <= pwdata[7:0];
                12'h080: m_sh_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_ready_high: assert property (pready) else $error("pready low");
    a_bad_addr_err: assert property (psel && penable && !ok_ix |-> pslverr)
        else $error("unmapped access not refused");
    a_good_addr_ok: assert property (psel && penable && ok_ix |-> !pslverr)
        else $error("mapped access refused");
    a_reset_clears: assert property (disable iff (1'b0) sys_rst && clk_en |=>
        !irq && !timer_a_out && !timer_b_out && prdata == 32'h0) else $error("reset state");
    a_ctrl_a_read: assert property (psel && penable && !pwrite && paddr == 12'h060
        && $past(clk_en) |-> prdata == {24'h0, a_sh_q}) else $error("ctrl a readback");
    a_ctrl_b_read: assert property (psel && penable && !pwrite && paddr == 12'h064
        && $past(clk_en) |-> prdata == {24'h0, b_sh_q}) else $error("ctrl b readback");
    a_stop_a_init: assert property (!a_sh_q[3] && !m16 && $stable(a_sh_q) && $past(clk_en)
        |-> timer_a_out == a_sh_q[7]) else $error("stopped a not at init");
    a_stop_b_init: assert property (!b_sh_q[3] && !m16 && $stable(b_sh_q)
        && $stable(a_sh_q) && $past(clk_en) |-> timer_b_out == b_sh_q[7])
        else $error("stopped b not at init");
    a_chain_follow: assert property (m16 && $past(m16) && $past(clk_en)
        |-> timer_b_out == $past(timer_a_out)) else $error("chained b output");
    a_mask_gates: assert property (m_sh_q == 8'h00 |-> !irq) else $error("irq while masked");
    a_freeze_hold: assert property (!clk_en |=> $stable(timer_a_out) && $stable(timer_b_out)
        && $stable(prdata)) else $error("state moved while frozen");
endmodule

bind dtc_top dtc_top_properties u_props
(
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .fs_pulse(fs_pulse), .timer_a_pin(timer_a_pin),
    .timer_b_pin(timer_b_pin), .timer_a_out(timer_a_out), .timer_b_out(timer_b_out), .irq(irq)
);

// [test/dtc_top_bench.sv]
// Self-checking bench for the dual timer control block
`timescale 1ns/1ps

module dtc_top_bench;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic        fs_pulse = 1'b0;
    logic        pin_a = 1'b0;
    logic        pin_b = 1'b0;
    wire         pready;
    wire  [31:0] prdata;
    wire         pslverr;
    wire         out_a;
    wire         out_b;
    wire         irq;
    integer      err_count = 0;
    integer      comparisons = 0;
    integer      n;
    logic [31:0] r;
    logic        e;
    logic [2:0]  ck;
    localparam [11:0] A_CTL = 12'h060, B_CTL = 12'h064, A_PER = 12'h068, A_PUL = 12'h06c;
    localparam [11:0] B_PER = 12'h070, MASK = 12'h080, STAT = 12'h07c, CNT = 12'h084;
    localparam [11:0] MISC = 12'h078;

    dtc_top DUT
    (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .fs_pulse(fs_pulse),
        .timer_a_pin(pin_a), .timer_b_pin(pin_b), .timer_a_out(out_a),
        .timer_b_out(out_b), .irq(irq)
    );

    // 50 MHz system clock
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Verdict, comparison and bus tasks
    // ------------------------------------------------------------
    task close_out;
    begin
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            err_count = err_count + 1;
        end
    end
    endtask

    // One APB transfer; waits for pready under a bound, then releases
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer k;
    begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k = k + 1;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            err_count = err_count + 1;
            close_out;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
    begin
        apb(1'b1, a, d);
    end
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp);
    begin
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    end
    endtask

    // Length in cycles of the next phase of out_a at level lvl
    task span(input logic lvl, output integer len);
        integer k;
    begin
        k = 0;
        while (out_a !== ~lvl && k < 300) begin @(posedge clk_sys); k = k + 1; end
        while (out_a !== lvl && k < 600) begin @(posedge clk_sys); k = k + 1; end
        len = 0;
        while (out_a === lvl && len < 300) begin @(posedge clk_sys); len = len + 1; end
        if (k >= 600 || len >= 300)
        begin
            chk(32'hdead, 32'h0);
            close_out;
        end
    end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rd(A_CTL, 32'h0);
        rd(B_CTL, 32'h0);
        wr(A_CTL, 32'hffff_ffa5);
        rd(A_CTL, 32'ha5);
        wr(B_CTL, 32'h52);
        rd(B_CTL, 32'h52);
        wr(A_CTL, 32'h0);
        wr(B_CTL, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        apb(1'b0, 12'h061, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Match event: sticky status, masked then unmasked interrupt
        wr(A_PER, 32'h3);
        wr(A_CTL, 32'h69);
        repeat (20) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        rd(STAT, 32'h1);
        wr(MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(A_CTL, 32'h61);
        rd(CNT, 32'h0);
        wr(STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rd(STAT, 32'h0);
        // Toggle spacing for several internal clock taps, period 3
        for (int i = 0; i < 3; i++)
        begin
            ck = (i == 0) ? 3'h6 : (i == 1) ? 3'h5 : 3'h3;
            wr(A_CTL, {24'h0, 1'b0, ck, 1'b1, 3'h1});
            span(1'b0, n);
            chk(n, (i == 0) ? 4 : (i == 1) ? 8 : 32);
            wr(A_CTL, {24'h0, 1'b0, ck, 1'b0, 3'h1});
        end
        // Pulse-width output: high from pulse match until period match
        wr(A_PER, 32'h7);
        wr(A_PUL, 32'h2);
        wr(A_CTL, 32'h6a);
        span(1'b1, n);
        chk(n, 5);
        span(1'b0, n);
        chk(n, 3);
        wr(A_CTL, 32'h62);
        // Chained mode: clock from A, run from B, period {B,A} = 0x100 so the high byte carries
        wr(A_PER, 32'h0);
        wr(B_PER, 32'h1);
        wr(A_CTL, 32'h63);
        wr(B_CTL, 32'h09);
        span(1'b0, n);
        chk(n, 257);
        wr(B_CTL, 32'h01);
        wr(A_CTL, 32'h03);
        // Count pins on both channels; the freeze below must miss a pin edge on A
        wr(A_PER, 32'hff);
        wr(B_PER, 32'hff);
        wr(A_CTL, 32'h79);
        wr(B_CTL, 32'h79);
        repeat (3)
        begin
            pin_a <= 1'b1;
            pin_b <= 1'b1;
            repeat (3) @(posedge clk_sys);
            pin_a <= 1'b0;
            pin_b <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
        rd(CNT, 32'h0303);
        clk_en <= 1'b0;
        pin_a <= 1'b1;
        repeat (6) @(posedge clk_sys);
        clk_en <= 1'b1;
        pin_a <= 1'b0;
        @(posedge clk_sys);
        rd(CNT, 32'h0303);
        // Second reset in mid-run
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rd(A_CTL, 32'h0);
        rd(CNT, 32'h0);
        // Low-speed mode: A on fs, B on fs/8 with period 0, so one B match
        wr(MISC, 32'h2);
        wr(A_PER, 32'hff);
        wr(B_PER, 32'h0);
        wr(A_CTL, 32'h49);
        wr(B_CTL, 32'h09);
        repeat (16)
        begin
            fs_pulse <= ~fs_pulse;
            repeat (3) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
        rd(CNT, 32'h0002_0008);
        rd(STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wr(MASK, 32'h2);
        chk({31'h0, irq}, 32'h1);
        close_out;
    end
endmodule
